// [rtl/icb_cycle_budget.sv]
// Cycle budget sequencer: reads, then writes, then idle clocks.
// Total equals the budget plus wait clocks.
// Assumes reset, halt and acknowledge are asynchronous pins.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Jump 8 to 14 clocks, 2 or 3 reads.
// RQ2: Call 16 to 22 clocks, two stack writes.
// RQ3: Address load 4, 8 or 12 clocks, no writes.
// RQ4: Address push 12 to 20 clocks, two writes.
// RQ5: Multi-register load 12+4n or 12+8n plus mode.
// RQ6: Multi-register store 8+4n or 8+8n; postincrement, PC refused.
// RQ7: Index width never changes cost.
// RQ8: Extend add, subtract, memory compare by size and form.
// RQ9: Decimal ops 6 in registers, 18(3/1) in memory.
// RQ10: Additive entries add address calculation figures.
// RQ11: Immediate logic on flags 20(3/0).
// RQ12: External reset 132(1/0), stop 4(0/0), simple 4(1/0).
// RQ13: Returns and frame ops have fixed figures.
// RQ14: Bounds check 10 plus address; status write 12, read 6.
// RQ15: Peripheral transfer 16 word, 24 long.
// RQ16: Exceptions include stacking and fetches.
// RQ17: Bus and address fault 50(4/7).
// RQ18: Traps 34, overflow 34(5/3), bounds 40, divide 38.
// RQ19: Interrupt 44(5/3), four-clock acknowledge.
// RQ20: After release, 40(6/0) before execution.
// RQ21: Totals count every clock, fetches included.
// RQ22: Late acknowledges add wait clocks.
module icb_cycle_budget (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic halt_pin_n,
  input wire logic mem_ack_n,
  input wire logic req_valid,
  input wire icb_pkg::icb_req_type req,
  output logic req_ready,
  output logic refused,
  output logic exec_enable,
  output logic bus_read_start,
  output logic bus_write_start,
  output logic bus_active,
  output logic done,
  output icb_pkg::icb_result_type result
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= icb_pkg::ICB_SYNC_RST;
      pin_s2_q <= icb_pkg::ICB_SYNC_RST;
    end else begin
      pin_s1_q <= {reset_pin_n, halt_pin_n, mem_ack_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire released = pin_s2_q[2] && pin_s2_q[1];
  wire reset_seen = !pin_s2_q[2];
  wire ack = !pin_s2_q[0];

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {st_boot, st_idle, st_look, st_bus, st_tail} icb_state_type;

  icb_state_type state_q;
  icb_state_type state_d;
  logic boot_q;
  logic exec_q;
  logic ready_q;
  logic refused_q;
  logic done_q;
  logic [5:0] rd_left_q;
  logic [5:0] wr_left_q;
  logic [9:0] tail_q;
  logic [10:0] tot_q;
  logic [5:0] rds_q;
  logic [5:0] wrs_q;
  logic [7:0] waits_q;
  icb_pkg::icb_result_type result_q;

  icb_pkg::icb_budget_type tab_bud;
  logic eng_active;
  logic eng_free;
  logic eng_wait;
  logic eng_rd_go;
  logic eng_wr_go;

  // ---------------------------------------------------------------
  // Budget lookup and bus cycle engine
  // ---------------------------------------------------------------
  wire accept = (state_q == st_idle) && req_valid;

  icb_budget_table u_table (
    .clk(clk),
    .resetn(resetn),
    .load(accept),
    .req(req),
    .bud(tab_bud)
  );

  // Reset sequence uses its own fixed budget
  wire icb_pkg::icb_budget_type sel = boot_q ? icb_pkg::ICB_RESET_EXC : tab_bud; // RQ20

  wire want_rd = (rd_left_q != 6'h00);
  wire want_wr = !want_rd && (wr_left_q != 6'h00);
  wire issue = (state_q == st_bus) && (want_rd || want_wr) && eng_free;

  icb_bus_cycle u_bus (
    .clk(clk),
    .resetn(resetn),
    .start(issue),
    .start_write(!want_rd),
    .ack(ack),
    .active(eng_active),
    .free(eng_free),
    .in_wait(eng_wait),
    .rd_go(eng_rd_go),
    .wr_go(eng_wr_go)
  );

  // ---------------------------------------------------------------
  // Budget split: bus clocks first, the rest as idle tail
  // ---------------------------------------------------------------
  wire [9:0] bus_clks = {1'b0, 7'(sel.rd) + 7'(sel.wr), 2'b00};
  wire [9:0] tail_init = (sel.clk > bus_clks) ? sel.clk - bus_clks : 10'h000; // RQ21

  // Bus and tail clocks count
  wire tick = eng_active || (state_q == st_tail); // RQ21
  wire [10:0] tot_next = tot_q + {10'h000, tick}; // RQ22
  wire bus_over = (state_q == st_bus) && !want_rd && !want_wr && eng_free;
  wire finish = (bus_over && (tail_q == 10'h000)) ||
                ((state_q == st_tail) && (tail_q == 10'h001));
  wire bad = (state_q == st_look) && !sel.legal;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_boot: begin
        if (released) begin
          state_d = st_look; // RQ20
        end
      end
      st_idle: begin
        if (req_valid) begin
          state_d = st_look;
        end
      end
      st_look: begin
        state_d = sel.legal ? st_bus : st_idle;
      end
      st_bus: begin
        if (bus_over) begin
          state_d = (tail_q == 10'h000) ? st_idle : st_tail;
        end
      end
      st_tail: begin
        if (tail_q == 10'h001) begin
          state_d = st_idle;
        end
      end
    endcase
    // A new reset abandons the run
    if (reset_seen) begin
      state_d = st_boot;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_boot;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == st_idle);
    end
  end

  // ---------------------------------------------------------------
  // Reset sequence and execution enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_q <= 1'b0;
      exec_q <= 1'b0;
    end else if (reset_seen) begin
      boot_q <= 1'b0;
      exec_q <= 1'b0;
    end else if ((state_q == st_boot) && released) begin
      boot_q <= 1'b1;
    end else if (finish && boot_q) begin
      boot_q <= 1'b0;
      exec_q <= 1'b1; // RQ20
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle and idle counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_left_q <= 6'h00;
      wr_left_q <= 6'h00;
    end else if (state_q == st_look) begin
      rd_left_q <= sel.legal ? sel.rd : 6'h00;
      wr_left_q <= sel.legal ? sel.wr : 6'h00;
    end else if (issue && want_rd) begin
      rd_left_q <= rd_left_q - 6'h01;
    end else if (issue) begin
      wr_left_q <= wr_left_q - 6'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tail_q <= 10'h000;
    end else if (state_q == st_look) begin
      tail_q <= tail_init; // RQ21
    end else if (state_q == st_tail) begin
      tail_q <= tail_q - 10'h001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tot_q <= 11'h000;
      waits_q <= 8'h00;
    end else if (state_q == st_look) begin
      tot_q <= 11'h000;
      waits_q <= 8'h00;
    end else begin
      tot_q <= tot_next;
      waits_q <= waits_q + {7'h00, eng_wait}; // RQ22
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rds_q <= 6'h00;
      wrs_q <= 6'h00;
    end else if (state_q == st_look) begin
      rds_q <= 6'h00;
      wrs_q <= 6'h00;
    end else if (issue && want_rd) begin
      rds_q <= rds_q + 6'h01;
    end else if (issue) begin
      wrs_q <= wrs_q + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Completion report
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      result_q <= '0;
    end else begin
      done_q <= finish && !reset_seen;
      refused_q <= bad && !reset_seen; // RQ6
      if (finish) begin
        result_q <= '{clk: tot_next, rd: rds_q, wr: wrs_q, waits: waits_q}; // RQ16 RQ19
      end
    end
  end

  assign req_ready = ready_q;
  assign refused = refused_q;
  assign exec_enable = exec_q;
  assign bus_read_start = eng_rd_go;
  assign bus_write_start = eng_wr_go;
  assign bus_active = eng_active;
  assign done = done_q;
  assign result = result_q;

endmodule

// [rtl/icb_pkg.sv]
// Shared types and cycle figures for the instruction cycle budget model.
// Assumes one 200 MHz clock; every figure is in external clock periods.
package icb_pkg;

  // ---------------------------------------------------------------
  // Bus and pin constants
  // ---------------------------------------------------------------
  // Last phase of a four-clock bus cycle
  localparam logic [1:0] ICB_BUS_LAST = 2'h3;
  // Synchroniser reset: all pins seen asserted
  localparam logic [2:0] ICB_SYNC_RST = 3'h0;

  // ---------------------------------------------------------------
  // Operation and addressing encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    icb_m_ind, icb_m_postinc, icb_m_predec, icb_m_disp, icb_m_idx, icb_m_absw,
    icb_m_absl, icb_m_pcdisp, icb_m_pcidx, icb_m_reg, icb_m_mem
  } icb_mode_type;

  typedef enum logic [4:0] {
    jump_unconditional, call_subroutine, load_computed_address, push_computed_address,
    mrt_load, mrt_store, add_with_extend, subtract_with_extend, compare_memory_postinc,
    decimal_add, decimal_subtract, logic_imm_flags, bounds_check, status_write,
    status_read, exchange_registers, simple_op, frame_link, frame_release, return_sub,
    return_from_exception, return_restore_flags, ext_reset, stop_op, periph_to_mem,
    periph_to_reg, exc_bus_fault, exc_trap, exc_overflow, exc_bounds, exc_div_zero,
    exc_interrupt
  } icb_op_type;

  typedef struct packed {
    icb_op_type op;
    icb_mode_type mode;
    logic long_sz;
    logic [4:0] regs;
    logic [7:0] ea_clk;
    logic [3:0] ea_rd;
    logic [3:0] ea_wr;
  } icb_req_type;

  typedef struct packed {
    logic [9:0] clk;
    logic [5:0] rd;
    logic [5:0] wr;
    logic legal;
  } icb_budget_type;

  typedef struct packed {
    logic [10:0] clk;
    logic [5:0] rd;
    logic [5:0] wr;
    logic [7:0] waits;
  } icb_result_type;

  function automatic icb_budget_type icb_bud(input logic [9:0] c, input logic [5:0] r,
                                             input logic [5:0] w);
    return '{clk: c, rd: r, wr: w, legal: 1'b1};
  endfunction

  // ---------------------------------------------------------------
  // Per-mode figures, indexed by icb_mode_type
  // ---------------------------------------------------------------
  localparam logic [9:0] ICB_JMP_CLK [11] = '{10'h008, 10'h000, 10'h000, 10'h00A,
    10'h00E, 10'h00A, 10'h00C, 10'h00A, 10'h00E, 10'h000, 10'h000};
  localparam logic [5:0] ICB_JMP_RD [11] = '{6'h02, 6'h00, 6'h00, 6'h02, 6'h03, 6'h02,
    6'h03, 6'h02, 6'h03, 6'h00, 6'h00};
  localparam logic [5:0] ICB_LEA_RD [11] = '{6'h01, 6'h00, 6'h00, 6'h02, 6'h02, 6'h02,
    6'h03, 6'h02, 6'h02, 6'h00, 6'h00};
  localparam logic [9:0] ICB_MRT_CLK_ADD [11] = '{10'h000, 10'h000, 10'h000, 10'h004,
    10'h006, 10'h004, 10'h008, 10'h004, 10'h006, 10'h000, 10'h000};
  localparam logic [5:0] ICB_MRT_RD_ADD [11] = '{6'h00, 6'h00, 6'h00, 6'h01, 6'h01,
    6'h01, 6'h02, 6'h01, 6'h01, 6'h00, 6'h00};
  localparam logic [10:0] ICB_CTRL_MODES = 11'h1F9;
  localparam logic [10:0] ICB_MRT_LD_MODES = 11'h1FB;
  localparam logic [10:0] ICB_MRT_ST_MODES = 11'h07D;
  localparam logic [9:0] ICB_CALL_EXTRA_CLK = 10'h008;
  localparam logic [9:0] ICB_PEA_EXTRA_CLK = 10'h008;
  localparam logic [9:0] ICB_LEA_CLK [11] = '{10'h004, 10'h000, 10'h000, 10'h008,
    10'h00C, 10'h008, 10'h00C, 10'h008, 10'h00C, 10'h000, 10'h000};
  localparam logic [5:0] ICB_CALL_MIN_RD = 6'h02;
  localparam logic [5:0] ICB_STACK_WR = 6'h02;

  // ---------------------------------------------------------------
  // Per-operation figures, indexed by icb_op_type
  // ---------------------------------------------------------------
  localparam logic [31:0] ICB_ADDITIVE = 32'h6000_1000;
  localparam logic [31:0] ICB_ADD_IF_MEM = 32'h0000_6000;
  localparam icb_budget_type ICB_OP_TAB [32] = '{
    icb_bud(10'h000, 6'h00, 6'h00), icb_bud(10'h000, 6'h00, 6'h00),
    icb_bud(10'h000, 6'h00, 6'h00), icb_bud(10'h000, 6'h00, 6'h00),
    icb_bud(10'h00C, 6'h03, 6'h00), icb_bud(10'h008, 6'h02, 6'h00),
    icb_bud(10'h004, 6'h01, 6'h00), icb_bud(10'h004, 6'h01, 6'h00),
    icb_bud(10'h00C, 6'h03, 6'h00), icb_bud(10'h006, 6'h01, 6'h00),
    icb_bud(10'h006, 6'h01, 6'h00), icb_bud(10'h014, 6'h03, 6'h00), // RQ11
    icb_bud(10'h00A, 6'h01, 6'h00), icb_bud(10'h00C, 6'h01, 6'h00), // RQ14
    icb_bud(10'h006, 6'h01, 6'h00), icb_bud(10'h006, 6'h01, 6'h00),
    icb_bud(10'h004, 6'h01, 6'h00), icb_bud(10'h010, 6'h02, 6'h02), // RQ12 RQ13
    icb_bud(10'h00C, 6'h03, 6'h00), icb_bud(10'h010, 6'h04, 6'h00), // RQ13
    icb_bud(10'h014, 6'h05, 6'h00), icb_bud(10'h014, 6'h02, 6'h00), // RQ13
    icb_bud(10'h084, 6'h01, 6'h00), icb_bud(10'h004, 6'h00, 6'h00), // RQ12
    icb_bud(10'h010, 6'h02, 6'h02), icb_bud(10'h010, 6'h04, 6'h00), // RQ15
    icb_bud(10'h032, 6'h04, 6'h07), icb_bud(10'h022, 6'h04, 6'h03), // RQ16 RQ17 RQ18
    icb_bud(10'h022, 6'h05, 6'h03), icb_bud(10'h028, 6'h04, 6'h03), // RQ18
    icb_bud(10'h026, 6'h04, 6'h03), icb_bud(10'h02C, 6'h05, 6'h03)  // RQ18 RQ19
  };
  localparam icb_budget_type ICB_MPX_REG_L = icb_bud(10'h008, 6'h01, 6'h00);
  localparam icb_budget_type ICB_MPX_MEM = icb_bud(10'h012, 6'h03, 6'h01);
  localparam icb_budget_type ICB_MPX_MEM_L = icb_bud(10'h01E, 6'h05, 6'h02);
  localparam icb_budget_type ICB_COMPARE_MEMORY_POSTINC_L = icb_bud(10'h014, 6'h05, 6'h00);
  localparam icb_budget_type ICB_DEC_MEM = icb_bud(10'h012, 6'h03, 6'h01);
  localparam icb_budget_type ICB_STR_MEM = icb_bud(10'h008, 6'h01, 6'h01);
  localparam icb_budget_type ICB_RESET_EXC = icb_bud(10'h028, 6'h06, 6'h00);
  localparam logic [5:0] ICB_STW_FULL_RD = 6'h02;
  localparam logic [9:0] ICB_PER_L_CLK = 10'h018;
  localparam logic [5:0] ICB_PER_R2M_L_WR = 6'h04;
  localparam logic [5:0] ICB_PER_M2R_L_RD = 6'h06;

endpackage

// [rtl/icb_bus_cycle.sv]
// One bus cycle: four clocks, stretched until ack.
// Assumes ack is synchronised; a start may land on the end clock.
`timescale 1ns/1ps
module icb_bus_cycle (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic start_write,
  input wire logic ack,
  output logic active,
  output logic free,
  output logic in_wait,
  output logic rd_go,
  output logic wr_go
);

  logic [1:0] ph_q;
  logic active_q;
  logic rd_go_q;
  logic wr_go_q;

  wire last = active_q && (ph_q == icb_pkg::ICB_BUS_LAST);
  wire ending = last && ack;
  wire take = start && free;

  assign in_wait = last && !ack; // RQ22
  assign free = !active_q || ending;
  assign active = active_q;
  assign rd_go = rd_go_q;
  assign wr_go = wr_go_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_q <= 1'b0;
      ph_q <= 2'h0;
    end else begin
      active_q <= take || (active_q && !ending);
      if (take) begin
        ph_q <= 2'h0;
      end else if (active_q && !last) begin
        ph_q <= ph_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_go_q <= 1'b0;
      wr_go_q <= 1'b0;
    end else begin
      rd_go_q <= take && !start_write;
      wr_go_q <= take && start_write;
    end
  end

endmodule

// [rtl/icb_budget_table.sv]
// Request to budget of clocks, reads and writes.
// Assumes load is a pulse; budget held until next load.
`timescale 1ns/1ps
module icb_budget_table (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire icb_pkg::icb_req_type req,
  output icb_pkg::icb_budget_type bud
);

  function automatic icb_pkg::icb_budget_type lookup(input icb_pkg::icb_req_type r);
    icb_pkg::icb_budget_type b;
    logic [5:0] nr;
    logic [9:0] nw;
    logic mem;
    b = icb_pkg::ICB_OP_TAB[r.op];
    nr = r.long_sz ? {r.regs, 1'b0} : {1'b0, r.regs};
    // Four clocks per word moved
    nw = {2'b00, nr, 2'b00};
    mem = (r.mode == icb_pkg::icb_m_mem);
    // Index width is not an input: both widths cost the same
    case (r.op) // RQ7
      icb_pkg::jump_unconditional: begin
        b.clk = icb_pkg::ICB_JMP_CLK[r.mode]; // RQ1
        b.rd = icb_pkg::ICB_JMP_RD[r.mode]; // RQ1
        b.legal = icb_pkg::ICB_CTRL_MODES[r.mode];
      end
      icb_pkg::call_subroutine: begin
        b.clk = icb_pkg::ICB_JMP_CLK[r.mode] + icb_pkg::ICB_CALL_EXTRA_CLK; // RQ2
        b.rd = (icb_pkg::ICB_LEA_RD[r.mode] < icb_pkg::ICB_CALL_MIN_RD) ?
               icb_pkg::ICB_CALL_MIN_RD : icb_pkg::ICB_LEA_RD[r.mode]; // RQ2
        b.wr = icb_pkg::ICB_STACK_WR; // RQ2
        b.legal = icb_pkg::ICB_CTRL_MODES[r.mode];
      end
      icb_pkg::load_computed_address: begin
        b.clk = icb_pkg::ICB_LEA_CLK[r.mode]; // RQ3
        b.rd = icb_pkg::ICB_LEA_RD[r.mode]; // RQ3
        b.legal = icb_pkg::ICB_CTRL_MODES[r.mode];
      end
      icb_pkg::push_computed_address: begin
        b.clk = icb_pkg::ICB_LEA_CLK[r.mode] + icb_pkg::ICB_PEA_EXTRA_CLK; // RQ4
        b.rd = icb_pkg::ICB_LEA_RD[r.mode]; // RQ4
        b.wr = icb_pkg::ICB_STACK_WR; // RQ4
        b.legal = icb_pkg::ICB_CTRL_MODES[r.mode];
      end
      icb_pkg::mrt_load: begin
        b.clk = b.clk + icb_pkg::ICB_MRT_CLK_ADD[r.mode] + nw; // RQ5
        b.rd = b.rd + icb_pkg::ICB_MRT_RD_ADD[r.mode] + nr; // RQ5
        b.legal = icb_pkg::ICB_MRT_LD_MODES[r.mode];
      end
      icb_pkg::mrt_store: begin
        b.clk = b.clk + icb_pkg::ICB_MRT_CLK_ADD[r.mode] + nw; // RQ6
        b.rd = b.rd + icb_pkg::ICB_MRT_RD_ADD[r.mode]; // RQ6
        b.wr = nr; // RQ6
        b.legal = icb_pkg::ICB_MRT_ST_MODES[r.mode]; // RQ6
      end
      icb_pkg::add_with_extend, icb_pkg::subtract_with_extend: begin
        if (mem) begin
          b = r.long_sz ? icb_pkg::ICB_MPX_MEM_L : icb_pkg::ICB_MPX_MEM; // RQ8
        end else if (r.long_sz) begin
          b = icb_pkg::ICB_MPX_REG_L; // RQ8
        end
      end
      icb_pkg::compare_memory_postinc: begin
        if (r.long_sz) begin
          b = icb_pkg::ICB_COMPARE_MEMORY_POSTINC_L; // RQ8
        end
      end
      icb_pkg::decimal_add, icb_pkg::decimal_subtract: begin
        if (mem) begin
          b = icb_pkg::ICB_DEC_MEM; // RQ9
        end
      end
      icb_pkg::status_write: begin
        if (r.long_sz) begin
          b.rd = icb_pkg::ICB_STW_FULL_RD; // RQ14
        end
      end
      icb_pkg::status_read: begin
        if (mem) begin
          b = icb_pkg::ICB_STR_MEM;
        end
      end
      icb_pkg::periph_to_mem: begin
        if (r.long_sz) begin
          b.clk = icb_pkg::ICB_PER_L_CLK; // RQ15
          b.wr = icb_pkg::ICB_PER_R2M_L_WR; // RQ15
        end
      end
      icb_pkg::periph_to_reg: begin
        if (r.long_sz) begin
          b.clk = icb_pkg::ICB_PER_L_CLK; // RQ15
          b.rd = icb_pkg::ICB_PER_M2R_L_RD; // RQ15
        end
      end
    endcase
    if (icb_pkg::ICB_ADDITIVE[r.op] || (mem && icb_pkg::ICB_ADD_IF_MEM[r.op])) begin
      b.clk = b.clk + {2'b00, r.ea_clk}; // RQ10
      b.rd = b.rd + {2'b00, r.ea_rd}; // RQ10
      b.wr = b.wr + {2'b00, r.ea_wr}; // RQ10
    end
    return b;
  endfunction

  icb_pkg::icb_budget_type bud_q;
  wire icb_pkg::icb_budget_type bud_d = lookup(req);

  assign bud = bud_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bud_q <= '0;
    end else if (load) begin
      bud_q <= bud_d;
    end
  end

endmodule

// [verif/icb_mem_model.sv]
// Memory partner: acknowledges a cycle after lat clocks.
// Assumes cycles are marked by start pulses and bus_active.
`timescale 1ns/1ps
module icb_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_active,
  input wire logic bus_read_start,
  input wire logic bus_write_start,
  input wire logic [3:0] lat,
  output logic mem_ack_n
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic starting;
  assign starting = bus_read_start || bus_write_start;
  assign cnt_d = starting ? 4'h1 : cnt_q + {3'h0, cnt_q != 4'hF};
  // Pull-up keeps the line high between cycles
  assign mem_ack_n = !(bus_active && cnt_q >= lat);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// [verif/icb_cycle_budget_sva.sv]
// Port-level timing checks for the sequencer.
// Assumes one clock domain; attached by the bind below.
`timescale 1ns/1ps
module icb_cycle_budget_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_ready,
  input wire logic refused,
  input wire logic exec_enable,
  input wire logic bus_read_start,
  input wire logic bus_write_start,
  input wire logic bus_active,
  input wire logic done,
  input wire icb_pkg::icb_result_type result
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_cycle_len: assert property (bus_read_start |-> bus_active[*4])
    else $error("read cycle too short");
  a_write_cycle_len: assert property (bus_write_start |-> bus_active[*4])
    else $error("write cycle too short");
  a_refused_quiet: assert property (refused |-> !bus_active && !done)
    else $error("refused touched bus");
  a_done_single: assert property (done |=> !done)
    else $error("done too long");
  a_boot_result: assert property ($rose(exec_enable) |-> done && result.clk == 11'h028
    && result.rd == 6'h06 && result.wr == 6'h00)
    else $error("reset sequence budget wrong");
  a_boot_no_write: assert property (!exec_enable |-> !bus_write_start)
    else $error("write during reset sequence");
  a_wait_account: assert property (done |-> int'(result.clk) >=
    4 * (result.rd + result.wr) + result.waits)
    else $error("total below bus clocks");
  a_done_idle: assert property (done |-> !bus_active ##[0:1] req_ready)
    else $error("done with bus busy");
endmodule
bind icb_cycle_budget icb_cycle_budget_sva u_sva (.clk(clk), .resetn(resetn),
  .req_ready(req_ready), .refused(refused), .exec_enable(exec_enable),
  .bus_read_start(bus_read_start), .bus_write_start(bus_write_start),
  .bus_active(bus_active), .done(done), .result(result));

// [verif/icb_cycle_budget_tb_top.sv]
// Self-checking bench for the sequencer.
// Assumes package, design, partner and checker compile first.
`timescale 1ns/1ps
module icb_cycle_budget_tb_top;
  logic clk, resetn, reset_pin_n, halt_pin_n, mem_ack_n, req_valid, req_ready, refused;
  logic exec_enable, bus_read_start, bus_write_start, bus_active, done;
  icb_pkg::icb_req_type req;
  icb_pkg::icb_result_type result;
  logic [3:0] lat;
  logic [31:0] s;
  int n_fail, checks;
  int jc[4] = '{8, 10, 14, 12};
  int jr[4] = '{2, 2, 3, 3};
  int cr[4] = '{2, 2, 2, 3};
  int lc[4] = '{4, 8, 12, 12};
  int lr[4] = '{1, 2, 2, 3};
  icb_pkg::icb_mode_type md[4] = '{icb_pkg::icb_m_ind, icb_pkg::icb_m_disp,
    icb_pkg::icb_m_idx, icb_pkg::icb_m_absl};
  always #2.5 clk = ~clk;
  icb_cycle_budget dut (.clk(clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
    .halt_pin_n(halt_pin_n), .mem_ack_n(mem_ack_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .refused(refused), .exec_enable(exec_enable),
    .bus_read_start(bus_read_start), .bus_write_start(bus_write_start),
    .bus_active(bus_active), .done(done), .result(result));
  icb_mem_model mem (.clk(clk), .resetn(resetn), .bus_active(bus_active),
    .bus_read_start(bus_read_start), .bus_write_start(bus_write_start), .lat(lat),
    .mem_ack_n(mem_ack_n));
  function automatic logic [31:0] lf(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [21:0] bud(int c, int r, int w);
    return {c[9:0], r[5:0], w[5:0]};
  endfunction
  function automatic logic [21:0] ex(icb_pkg::icb_req_type q, int i);
    int n, ec, er, ew;
    logic m, l;
    n = q.regs;
    ec = q.ea_clk;
    er = q.ea_rd;
    ew = q.ea_wr;
    m = q.mode == icb_pkg::icb_m_mem;
    l = q.long_sz;
    // Labels follow the operation order of the package
    case (int'(q.op))
      0: return bud(jc[i], jr[i], 0);
      1: return bud(jc[i] + 8, cr[i], 2);
      2: return bud(lc[i], lr[i], 0);
      3: return bud(lc[i] + 8, lr[i], 2);
      4: return l ? bud(12 + 8 * n, 3 + 2 * n, 0) : bud(12 + 4 * n, 3 + n, 0);
      5: return l ? bud(8 + 8 * n, 2, 2 * n) : bud(8 + 4 * n, 2, n);
      6, 7: return m ? (l ? bud(30, 5, 2) : bud(18, 3, 1)) : bud(l ? 8 : 4, 1, 0);
      8: return l ? bud(20, 5, 0) : bud(12, 3, 0);
      9, 10: return m ? bud(18, 3, 1) : bud(6, 1, 0);
      11: return bud(20, 3, 0);
      12: return bud(10 + ec, 1 + er, ew);
      13: return bud(12, l ? 2 : 1, 0);
      14, 15: return bud(6, 1, 0);
      16: return bud(4, 1, 0);
      17: return bud(16, 2, 2);
      18: return bud(12, 3, 0);
      19: return bud(16, 4, 0);
      20: return bud(20, 5, 0);
      21: return bud(20, 2, 0);
      22: return bud(132, 1, 0);
      23: return bud(4, 0, 0);
      24: return l ? bud(24, 2, 4) : bud(16, 2, 2);
      25: return l ? bud(24, 6, 0) : bud(16, 4, 0);
      26: return bud(50, 4, 7);
      28: return bud(34, 5, 3);
      29: return bud(40 + ec, 4 + er, 3 + ew);
      30: return bud(38 + ec, 4 + er, 3 + ew);
      31: return bud(44, 5, 3);
      default: return bud(34, 4, 3);
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic fin(input logic [21:0] e, input logic rf);
    int nr = 0, nw = 0, t = 0;
    do begin
      @(negedge clk);
      t++;
      nr += bus_read_start;
      nw += bus_write_start;
    end while (done !== 1'b1 && refused !== 1'b1 && t < 999);
    if (t >= 999) begin
      n_fail++;
      results();
    end
    if (rf) begin
      chk("refused", refused, 1);
      chk("bus", nr + nw, 0);
    end else begin
      chk("clk", result.clk - result.waits, e[21:12]);
      chk("rd", result.rd, e[11:6]);
      chk("wr", result.wr, e[5:0]);
      chk("reads", nr, e[11:6]);
      chk("writes", nw, e[5:0]);
      chk("waits", result.waits != 0, lat != 0);
    end
  endtask
  task automatic run(input icb_pkg::icb_req_type q, input logic [21:0] e, input logic rf);
    int k = 0;
    @(posedge clk);
    req <= q;
    req_valid <= 1'b1;
    do begin
      @(negedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 99);
    @(posedge clk);
    req_valid <= 1'b0;
    fin(e, rf);
  endtask
  initial begin
    icb_pkg::icb_req_type q;
    int i, k, o;
    clk = 1'b0;
    {resetn, reset_pin_n, halt_pin_n, req_valid} = 4'h0;
    req = '0;
    lat = 4'h0;
    s = 32'h4B7951AE;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (10) @(negedge clk);
    chk("boot", exec_enable, 0);
    @(posedge clk);
    halt_pin_n <= 1'b1;
    fin(bud(40, 6, 0), 1'b0);
    chk("enable", exec_enable, 1);
    for (k = 0; k < 64; k++) begin
      s = lf(s);
      i = s[1:0];
      o = k / 2;
      q = '0;
      q.op = icb_pkg::icb_op_type'(o);
      q.long_sz = s[2];
      q.regs = (o == 4 || o == 5) ? (k[0] ? 5'h00 : 5'h10) : 5'(s[8:4] % 17);
      q.ea_rd = {2'h0, s[10:9]};
      q.ea_wr = {3'h0, s[11]};
      q.ea_clk = 8'(4 * (s[10:9] + s[11]) + 2 * s[12]);
      q.mode = o < 4 ? md[i] : o < 6 ? icb_pkg::icb_m_ind : (o == 8 ||
        (s[3] && o inside {6, 7, 9, 10})) ? icb_pkg::icb_m_mem : icb_pkg::icb_m_reg;
      run(q, ex(q, i), 1'b0);
    end
    q = '0;
    q.op = icb_pkg::mrt_store;
    q.mode = icb_pkg::icb_m_postinc;
    run(q, '0, 1'b1);
    q.mode = icb_pkg::icb_m_pcdisp;
    run(q, '0, 1'b1);
    lat <= 4'h3;
    q.op = icb_pkg::call_subroutine;
    q.mode = icb_pkg::icb_m_ind;
    run(q, bud(16, 2, 2), 1'b0);
    lat <= 4'h0;
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk("abort", exec_enable, 0);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    fin(bud(40, 6, 0), 1'b0);
    results();
  end
endmodule
